/* File: rtl/scs_defs.svh */
// constants for the sdram command block: widths, field positions, reset values, timing
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ==========================================================
// address and field layout
`define SCS_ROW_W 12
`define SCS_COL_W 9
`define SCS_ARR_AW 23
`define SCS_AP_BIT 10
`define SCS_MR_BL_HI 2
`define SCS_MR_BL_LO 0
`define SCS_MR_WB_BIT 9
`define SCS_BL_FULL 3'h7
`define SCS_EMR_BANK 2'h2
`define SCS_MR_BANK 2'h0

// ==========================================================
// reset values (no reset pin on the part; these are power-up choices)
`define SCS_MR_RESET 12'h000
`define SCS_EMR_RESET 12'h000

// ==========================================================
// timing
`define SCS_CLK_NS 10
`define SCS_SR_INTERVAL_NS 15625
`define SCS_SR_CYCLES (`SCS_SR_INTERVAL_NS / `SCS_CLK_NS)

// ==========================================================
// write data buffer
`define SCS_FIFO_DEPTH 8
`define SCS_FIFO_W 41

`endif

/* File: rtl/scs_pkg.sv */
// types shared by the sdram command block
package scs_pkg;

  // ==========================================================
  // power state, gray along normal<->self and normal<->deep
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_SELF = 2'h1,
    PWR_DEEP = 2'h2
  } scs_pwr_t;

  // ==========================================================
  // decoded command
  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACTIVE = 4'h2,
    CMD_READ = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_TERM = 4'h5,
    CMD_PRECHARGE = 4'h6,
    CMD_REFRESH = 4'h7,
    CMD_MODE = 4'h8
  } scs_cmd_t;

  // ==========================================================
  // complete state of the command block
  typedef struct packed {
    logic [11:0] modeReg;
    logic [11:0] extModeReg;
    logic [3:0] bankOpen;
    logic [3:0][11:0] openRow;
    logic [11:0] refreshRow;
    scs_pwr_t pwr;
    logic [10:0] srTimer;
    logic burstOn;
    logic burstWrite;
    logic burstAutoPre;
    logic burstFull;
    logic [1:0] burstBank;
    logic [8:0] burstCol;
    logic [8:0] burstLeft;
    logic [8:0] burstWrap;
    logic [1:0] mask1;
    logic [1:0] mask2;
    logic rdPend;
    logic arrRdEn;
    logic [22:0] arrRdAddr;
    logic [15:0] dqOut;
    logic [15:0] dqOe;
    logic refreshStrobe;
    logic arrayOff;
    logic wrDropped;
  } scs_state_t;

endpackage

/* File: rtl/scs_fifo.sv */
// write data buffer between the command block and the array write port
`timescale 1ns/10ps
module scs_fifo import scs_pkg::*; #(
  parameter int W = 41,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic outValid;
    logic [W-1:0] outData;
  } scs_fifo_state_t;

  scs_fifo_state_t q;
  scs_fifo_state_t d;
  logic push;
  logic pop;

  // ==========================================================
  // next state
  // the output word sits in its own register so the drain side sees a flop
  always_comb begin
    d = q;
    push = inValid && inReady;
    pop = (q.count != '0) && (!q.outValid || outReady);
    if (q.outValid && outReady) begin
      d.outValid = 1'b0;
    end
    if (pop) begin
      d.outData = q.mem[q.rdPtr];
      d.outValid = 1'b1;
      d.rdPtr = AW'(q.rdPtr + 1'b1);
    end
    if (push) begin
      d.mem[q.wrPtr] = inData;
      d.wrPtr = AW'(q.wrPtr + 1'b1);
    end
    d.count = (AW + 1)'(q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign inReady = (q.count != (AW + 1)'(DEPTH));
  assign outValid = q.outValid;
  assign outData = q.outData;

endmodule

/* File: rtl/scs_sdram_cmd.sv */
// command decode, bank, burst and power state logic of a four-bank mobile sdram
`timescale 1ns/10ps
`include "scs_defs.svh"
module scs_sdram_cmd import scs_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // command pins
  input wire logic cke,
  input wire logic csB,
  input wire logic rasB,
  input wire logic casB,
  input wire logic weB,
  input wire logic bankSel0,
  input wire logic bankSel1,
  input wire logic [11:0] addr,
  input wire logic lowByteMask,
  input wire logic highByteMask,
  // data pins
  input wire logic [15:0] dqIn,
  output logic [15:0] dqOut,
  output logic [15:0] dqOe,
  // array read port, data returned one cycle after the address
  output logic arrRdEn,
  output logic [22:0] arrRdAddr,
  input wire logic [15:0] arrRdData,
  // array write port
  output logic arrWrValid,
  input wire logic arrWrReady,
  output logic [22:0] arrWrAddr,
  output logic [15:0] arrWrData,
  output logic [1:0] arrWrByteEn,
  // refresh and power status
  output logic refreshStrobe,
  output logic [11:0] refreshRow,
  output logic arrayOff,
  output logic selfRefreshOn,
  output logic wrDropped
);

  scs_state_t q;
  scs_state_t d;
  scs_cmd_t cmd;
  logic [1:0] bank;
  logic [1:0] maskIn;
  logic [8:0] blLeft;
  logic [8:0] blWrap;
  logic blFull;
  logic beatDo;
  logic beatWrite;
  logic [1:0] beatBank;
  logic [8:0] beatCol;
  logic pushValid;
  logic pushReady;
  logic [`SCS_FIFO_W-1:0] pushWord;
  logic [`SCS_FIFO_W-1:0] popWord;

  assign bank = {bankSel1, bankSel0};
  assign maskIn = {highByteMask, lowByteMask};

  // ==========================================================
  // command decode
  always_comb begin
    if (csB) begin
      cmd = CMD_INHIBIT;
    end else begin
      unique case ({rasB, casB, weB})
        3'h7: cmd = CMD_NOP;
        3'h3: cmd = CMD_ACTIVE;
        3'h5: cmd = CMD_READ;
        3'h4: cmd = CMD_WRITE;
        3'h6: cmd = CMD_TERM;
        3'h2: cmd = CMD_PRECHARGE;
        3'h1: cmd = CMD_REFRESH;
        3'h0: cmd = CMD_MODE;
      endcase
    end
  end

  // ==========================================================
  // burst length from the mode register; reserved codes act as one beat
  always_comb begin
    blFull = 1'b0;
    unique case (q.modeReg[`SCS_MR_BL_HI:`SCS_MR_BL_LO])
      3'h1: blLeft = 9'h001;
      3'h2: blLeft = 9'h003;
      3'h3: blLeft = 9'h007;
      `SCS_BL_FULL: begin
        blLeft = 9'h1ff;
        blFull = 1'b1;
      end
      default: blLeft = 9'h000;
    endcase
    blWrap = blLeft;
  end

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    beatDo = 1'b0;
    beatWrite = 1'b0;
    beatBank = q.burstBank;
    beatCol = q.burstCol;
    d.arrRdEn = 1'b0;
    d.refreshStrobe = 1'b0;
    // read data pipeline: address, array, pin register
    d.rdPend = q.arrRdEn;
    d.mask1 = maskIn;
    d.mask2 = q.mask1;
    d.dqOut = arrRdData;
    d.dqOe = {{8{q.rdPend && !q.mask2[1]}}, {8{q.rdPend && !q.mask2[0]}}};

    unique case (q.pwr)
      PWR_SELF: begin
        // all inputs other than clock enable are ignored here
        if (cke) begin
          d.pwr = PWR_NORMAL;
          d.srTimer = '0;
        end else if (q.srTimer == 11'(`SCS_SR_CYCLES - 1)) begin
          d.srTimer = '0;
          d.refreshStrobe = 1'b1;
          d.refreshRow = q.refreshRow + 12'h001;
        end else begin
          d.srTimer = q.srTimer + 11'h001;
        end
      end
      PWR_DEEP: begin
        // mode registers are simply left alone across the whole stay
        if (cke) begin
          d.pwr = PWR_NORMAL;
          d.arrayOff = 1'b0;
        end
      end
      PWR_NORMAL: begin
        if (!cke) begin
          if (cmd == CMD_REFRESH) begin
            d.pwr = PWR_SELF;
            d.srTimer = '0;
            d.burstOn = 1'b0;
          end else if (cmd == CMD_TERM) begin
            d.pwr = PWR_DEEP;
            d.arrayOff = 1'b1;
            d.bankOpen = '0;
            d.burstOn = 1'b0;
          end
        end else begin
          if ((cmd == CMD_READ || cmd == CMD_WRITE) && q.bankOpen[bank]) begin
            // a new access truncates the running one; a pending auto
            // precharge of the truncated burst still closes its bank
            if (q.burstOn && q.burstAutoPre && !q.burstFull) begin
              d.bankOpen[q.burstBank] = 1'b0;
            end
            beatDo = 1'b1;
            beatWrite = (cmd == CMD_WRITE);
            beatBank = bank;
            beatCol = addr[8:0];
            d.burstBank = bank;
            d.burstWrite = (cmd == CMD_WRITE);
            d.burstAutoPre = addr[`SCS_AP_BIT];
            d.burstFull = blFull;
            d.burstWrap = blFull ? 9'h1ff : blWrap;
            d.burstLeft = (cmd == CMD_WRITE && q.modeReg[`SCS_MR_WB_BIT]) ? 9'h000 : blLeft;
            d.burstCol = (addr[8:0] & ~d.burstWrap) | ((addr[8:0] + 9'h001) & d.burstWrap);
            if (d.burstLeft == 9'h000 && !blFull) begin
              d.burstOn = 1'b0;
              if (addr[`SCS_AP_BIT]) begin
                d.bankOpen[bank] = 1'b0;
              end
            end else begin
              d.burstOn = 1'b1;
            end
          end else if (cmd == CMD_TERM) begin
            d.burstOn = 1'b0;
          end else if (q.burstOn) begin
            beatDo = 1'b1;
            beatWrite = q.burstWrite;
            d.burstCol = (q.burstCol & ~q.burstWrap) | ((q.burstCol + 9'h001) & q.burstWrap);
            if (q.burstFull) begin
              d.burstOn = 1'b1;
            end else if (q.burstLeft == 9'h001) begin
              d.burstOn = 1'b0;
              if (q.burstAutoPre) begin
                d.bankOpen[q.burstBank] = 1'b0;
              end
            end else begin
              d.burstLeft = q.burstLeft - 9'h001;
            end
          end
          unique case (cmd)
            CMD_ACTIVE: begin
              d.bankOpen[bank] = 1'b1;
              d.openRow[bank] = addr;
            end
            CMD_PRECHARGE: begin
              if (addr[`SCS_AP_BIT]) begin
                d.bankOpen = '0;
                d.burstOn = 1'b0;
              end else begin
                d.bankOpen[bank] = 1'b0;
                if (q.burstBank == bank) begin
                  d.burstOn = 1'b0;
                end
              end
            end
            CMD_REFRESH: begin
              d.refreshStrobe = 1'b1;
              d.refreshRow = q.refreshRow + 12'h001;
            end
            CMD_MODE: begin
              if (bank == `SCS_EMR_BANK) begin
                d.extModeReg = addr;
              end else if (bank == `SCS_MR_BANK) begin
                d.modeReg = addr;
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        d.pwr = PWR_NORMAL;
      end
    endcase

    // one array beat per cycle, read or write
    pushValid = beatDo && beatWrite;
    pushWord = {beatBank, q.openRow[beatBank], beatCol, ~maskIn, dqIn};
    if (pushValid && !pushReady) begin
      d.wrDropped = 1'b1;
    end
    if (beatDo && !beatWrite) begin
      d.arrRdEn = 1'b1;
      d.arrRdAddr = {beatBank, q.openRow[beatBank], beatCol};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.modeReg <= `SCS_MR_RESET;
      q.extModeReg <= `SCS_EMR_RESET;
      q.pwr <= PWR_NORMAL;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // write buffer; a full buffer drops the beat and sets the sticky flag,
  // since the pins cannot be stalled
  scs_fifo #(
    .W(`SCS_FIFO_W),
    .DEPTH(`SCS_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushWord),
    .outValid(arrWrValid),
    .outReady(arrWrReady),
    .outData(popWord)
  );

  assign arrWrAddr = popWord[40:18];
  assign arrWrByteEn = popWord[17:16];
  assign arrWrData = popWord[15:0];
  assign dqOut = q.dqOut;
  assign dqOe = q.dqOe;
  assign arrRdEn = q.arrRdEn;
  assign arrRdAddr = q.arrRdAddr;
  assign refreshStrobe = q.refreshStrobe;
  assign refreshRow = q.refreshRow;
  assign arrayOff = q.arrayOff;
  assign selfRefreshOn = q.pwr[0];
  assign wrDropped = q.wrDropped;

endmodule

/* File: bench/scs_sdram_cmd_monitor.sv */
// checker for command decode, read mask and power state at the block pins
`timescale 1ns/10ps
module scs_sdram_cmd_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // command pins
  input wire logic cke,
  input wire logic csB,
  input wire logic rasB,
  input wire logic casB,
  input wire logic weB,
  input wire logic bankSel0,
  input wire logic bankSel1,
  input wire logic lowByteMask,
  input wire logic highByteMask,
  // watched outputs
  input wire logic [15:0] dqOe,
  input wire logic arrRdEn,
  input wire logic refreshStrobe,
  input wire logic arrayOff,
  input wire logic selfRefreshOn
);
  wire [3:0] pins = {csB, rasB, casB, weB};
  wire [1:0] bank = {bankSel1, bankSel0};
  wire awake = !selfRefreshOn && !arrayOff;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========
  // command steps
  sequence self_in_s; !cke && pins == 4'h1 && awake; endsequence
  sequence deep_in_s; !cke && pins == 4'h6 && awake; endsequence
  sequence ref_in_s; cke && pins == 4'h1 && awake; endsequence
  sequence act_s; cke && pins == 4'h3 && awake; endsequence
  sequence idle_s; cke && (csB || pins == 4'h7); endsequence
  sequence act_rd_s; act_s ##1 idle_s [*2] ##1 (cke && pins == 4'h5 && bank == $past(bank, 3));
  endsequence
  // ==========
  // checks
  self_enter_a: assert property (self_in_s |=> selfRefreshOn)
    else $error("self refresh not entered");
  self_stay_a: assert property (selfRefreshOn && !cke |=> selfRefreshOn)
    else $error("self refresh left with clock enable low");
  deep_enter_a: assert property (deep_in_s |=> arrayOff)
    else $error("deep power-down not entered");
  deep_exit_a: assert property (arrayOff && cke |=> !arrayOff)
    else $error("deep power-down not left");
  auto_ref_a: assert property (ref_in_s |=> refreshStrobe)
    else $error("auto refresh gave no strobe");
  act_read_a: assert property (act_rd_s |=> arrRdEn)
    else $error("read to open row gave no beat");
  low_mask_a: assert property (dqOe[0] |-> !$past(lowByteMask, 3))
    else $error("low byte driven under mask");
  high_mask_a: assert property (dqOe[8] |-> !$past(highByteMask, 3))
    else $error("high byte driven under mask");
endmodule

bind scs_sdram_cmd scs_sdram_cmd_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b), .cke(cke),
  .csB(csB), .rasB(rasB), .casB(casB), .weB(weB), .bankSel0(bankSel0), .bankSel1(bankSel1),
  .lowByteMask(lowByteMask), .highByteMask(highByteMask), .dqOe(dqOe), .arrRdEn(arrRdEn),
  .refreshStrobe(refreshStrobe), .arrayOff(arrayOff), .selfRefreshOn(selfRefreshOn));

/* File: bench/scs_ctrl_model.sv */
// memory controller model driving the command, mask and write data pins
`timescale 1ns/10ps
module scs_ctrl_model #(
  parameter int GAP = 2
) (
  // clock
  input wire logic clk_sys,
  // command pins
  output logic cke,
  output logic csB,
  output logic rasB,
  output logic casB,
  output logic weB,
  output logic bankSel0,
  output logic bankSel1,
  output logic [11:0] addr,
  output logic lowByteMask,
  output logic highByteMask,
  output logic [15:0] dqIn
);
  initial begin
    {cke, csB, rasB, casB, weB} = 5'h1f;
    {bankSel1, bankSel0, addr, highByteMask, lowByteMask, dqIn} = '0;
  end
  // nops follow every command for GAP cycles, covering the delay after it;
  // address and data show the inverse so a stale value cannot pass as held
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
      input logic k, input logic [1:0] m, input logic [15:0] d);
    @(posedge clk_sys);
    {csB, rasB, casB, weB} <= c;
    {bankSel1, bankSel0} <= b;
    addr <= a;
    cke <= k;
    {highByteMask, lowByteMask} <= m;
    dqIn <= d;
    repeat (GAP) begin
      @(posedge clk_sys);
      {csB, rasB, casB, weB} <= 4'h7;
      addr <= ~a;
      dqIn <= ~d;
    end
  endtask
  task automatic wake(input int stay);
    repeat (stay) @(posedge clk_sys);
    cke <= 1'b1;
    cmd(4'h7, 2'h0, 12'h0, 1'b1, 2'h0, 16'h0);
    cmd(4'h1, 2'h0, 12'h0, 1'b1, 2'h0, 16'h0);
  endtask
endmodule

/* File: bench/tb.sv */
// self-checking bench for the sdram command block
`timescale 1ns/10ps
module tb;
  import scs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cke, csB, rasB, casB, weB, bankSel0, bankSel1, lowByteMask, highByteMask;
  logic [11:0] addr, refreshRow, row, r0;
  logic [15:0] dqIn, dqOut, dqOe, arrWrData, d;
  logic [15:0] arrRdData = 16'h0;
  logic [22:0] arrRdAddr, arrWrAddr, lastRd;
  logic [1:0] arrWrByteEn, bk;
  logic [8:0] col;
  logic [7:0] lastHi;
  logic arrRdEn, arrWrValid, refreshStrobe, arrayOff, selfRefreshOn, wrDropped;
  logic arrWrReady = 1'b1;
  logic hold = 1'b0;
  logic [40:0] expWr[$];
  int fails = 0, n_compared = 0, nRd = 0, nLo = 0, nHi = 0, nStr = 0, i, s, t;
  always #5 clk_sys = ~clk_sys;

  scs_ctrl_model #(.GAP(2)) u_ctrl (.clk_sys(clk_sys), .cke(cke), .csB(csB), .rasB(rasB),
    .casB(casB), .weB(weB), .bankSel0(bankSel0), .bankSel1(bankSel1), .addr(addr),
    .lowByteMask(lowByteMask), .highByteMask(highByteMask), .dqIn(dqIn));
  scs_sdram_cmd u_scs_sdram_cmd (.clk_sys(clk_sys), .rst_b(rst_b), .cke(cke), .csB(csB),
    .rasB(rasB), .casB(casB), .weB(weB), .bankSel0(bankSel0), .bankSel1(bankSel1),
    .addr(addr), .lowByteMask(lowByteMask), .highByteMask(highByteMask), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .arrRdEn(arrRdEn), .arrRdAddr(arrRdAddr),
    .arrRdData(arrRdData), .arrWrValid(arrWrValid), .arrWrReady(arrWrReady),
    .arrWrAddr(arrWrAddr), .arrWrData(arrWrData), .arrWrByteEn(arrWrByteEn),
    .refreshStrobe(refreshStrobe), .refreshRow(refreshRow), .arrayOff(arrayOff),
    .selfRefreshOn(selfRefreshOn), .wrDropped(wrDropped));

  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] v);
    n_compared++;
    if (v !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    u_ctrl.cmd(c, b, a, 1'b1, 2'h0, 16'h0);
  endtask
  task automatic rd(input logic [1:0] b, input logic [11:0] a, input int n);
    s = nRd;
    op(4'h5, b, a);
    repeat (8) @(posedge clk_sys);
    chk("readBeats", n, nRd - s);
  endtask

  // ==========
  // array side: read data one cycle after the address, random drain stalls
  always @(posedge clk_sys) begin
    arrRdData <= arrRdAddr[15:0] ^ 16'h5a5a;
    arrWrReady <= hold ? 1'b0 : 1'($urandom);
    if (arrRdEn === 1'b1) begin
      nRd <= nRd + 1;
      lastRd <= arrRdAddr;
    end
    if (dqOe[0] === 1'b1) nLo <= nLo + 1;
    if (dqOe[8] === 1'b1) begin
      nHi <= nHi + 1;
      lastHi <= dqOut[15:8];
    end
    if (refreshStrobe === 1'b1) nStr <= nStr + 1;
    if (rst_b && arrWrValid === 1'b1 && arrWrReady)
      chk("arrWr", expWr.size() ? expWr.pop_front() : '1,
        {arrWrAddr, arrWrData, arrWrByteEn});
  end

  // ==========
  // main sequence
  initial begin
    void'($urandom(19382));
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    bk = 2'($urandom);
    row = 12'($urandom);
    col = 9'($urandom);
    d = 16'($urandom);
    op(4'h3, bk, row);
    s = nLo;
    t = nHi;
    u_ctrl.cmd(4'h5, bk, {3'h0, col}, 1'b1, 2'h1, 16'h0);
    repeat (8) @(posedge clk_sys);
    chk("rdAddr", {bk, row, col}, lastRd);
    chk("loBeats", 0, nLo - s);
    chk("hiBeats", 1, nHi - t);
    chk("rdData", 8'(({bk, row, col} ^ 23'h5a5a) >> 8), lastHi);
    expWr.push_back({bk, row, col, d, 2'h2});
    u_ctrl.cmd(4'h4, bk, {3'h0, col}, 1'b1, 2'h1, d);
    rd(bk, 12'h400, 1);
    rd(bk, 12'h000, 0);
    op(4'h3, bk, row);
    rd(bk, 12'h000, 1);
    rd(bk, 12'h000, 1);
    op(4'h3, bk ^ 2'h1, row);
    op(4'h2, bk ^ 2'h1, 12'h000);
    rd(bk, 12'h000, 1);
    rd(bk ^ 2'h1, 12'h000, 0);
    op(4'h2, bk ^ 2'h1, 12'h400);
    rd(bk, 12'h000, 0);
    s = nStr;
    r0 = refreshRow;
    op(4'h1, 2'h3, 12'hfff);
    repeat (3) @(posedge clk_sys);
    chk("refStrobe", 1, nStr - s);
    chk("refRow", 12'(r0 + 12'h1), refreshRow);
    // buffer: 9 words fit with the drain stalled, the tenth is dropped
    op(4'h3, bk, row);
    hold = 1'b1;
    for (i = 0; i < 10; i++) begin
      d = 16'($urandom);
      if (i < 9) expWr.push_back({bk, row, 9'(i), d, 2'h3});
      u_ctrl.cmd(4'h4, bk, 12'(i), 1'b1, 2'h0, d);
    end
    chk("wrDropped", 1, wrDropped);
    hold = 1'b0;
    for (i = 0; i < 300 && expWr.size() > 0; i++) @(posedge clk_sys);
    chk("drained", 0, expWr.size());
    if (expWr.size() != 0) test_done();
    op(4'h2, 2'h0, 12'h400);
    op(4'h0, 2'h0, 12'h002);
    op(4'h0, 2'h2, 12'h000);
    u_ctrl.cmd(4'h6, 2'h0, 12'h0, 1'b0, 2'h0, 16'h0);
    chk("arrayOff", 1, arrayOff);
    u_ctrl.wake(4);
    chk("arrayOn", 0, arrayOff);
    op(4'h3, bk, row);
    rd(bk, 12'h000, 4);
    // single-write mode: a write stores one beat even with a burst length of four
    op(4'h2, 2'h0, 12'h400);
    op(4'h0, 2'h0, 12'h202);
    op(4'h3, bk, row);
    expWr.push_back({bk, row, 9'h005, d, 2'h3});
    u_ctrl.cmd(4'h4, bk, 12'h005, 1'b1, 2'h0, d);
    repeat (20) @(posedge clk_sys);
    chk("singleWr", 0, expWr.size());
    op(4'h2, 2'h0, 12'h400);
    op(4'h0, 2'h0, 12'h007);
    op(4'h3, bk, row);
    op(4'h5, bk, 12'h400);
    op(4'h6, bk, 12'h000);
    repeat (4) @(posedge clk_sys);
    rd(bk, 12'h000, 8);
    op(4'h6, bk, 12'h000);
    op(4'h2, 2'h0, 12'h400);
    u_ctrl.cmd(4'h1, 2'h0, 12'h0, 1'b0, 2'h0, 16'h0);
    chk("selfOn", 1, selfRefreshOn);
    s = nStr;
    repeat (1600) @(posedge clk_sys);
    chk("selfStrobe", 1, nStr - s);
    u_ctrl.wake(0);
    chk("selfOff", 0, selfRefreshOn);
    test_done();
  end
endmodule
